/* File: rtl/fsps_device.sv */
// Flash self-programming sequencer: control register, page buffer, timer.
// Assumes eeprom_busy comes from logic on ref_clk and the flash array
// accepts an erase pulse and a word stream at the end of a page write.
module fsps_device #(
  parameter logic [15:0] PROG_CYCLES = fsps_pkg::PROG_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  fsps_if.device link,
  input wire logic eeprom_busy,
  output logic flash_busy,
  output logic flash_erase,
  output logic [9:0] flash_erase_page,
  output logic flash_prog_valid,
  output logic [9:0] flash_prog_page,
  output logic [4:0] flash_prog_word,
  output logic [15:0] flash_prog_data,
  output logic flash_prog_loaded
);
  fsps_pkg::fsps_dev_state_type state_reg;
  logic [7:0] ctrl_reg;
  logic [2:0] window_reg;
  logic [15:0] timer_reg;
  logic halt_reg;
  logic [9:0] page_reg;
  logic [4:0] idx_reg;
  logic erase_reg;
  logic prog_valid_reg;
  logic [4:0] prog_word_reg;
  logic [15:0] prog_data_reg;
  logic prog_loaded_reg;
  logic [15:0] buf_reg [fsps_pkg::WORDS];
  logic [fsps_pkg::WORDS-1:0] mask_reg;
  logic spm_hit;
  logic load_hit;
  logic buf_clr;
  logic write_done;
  logic [4:0] z_word;
  logic [9:0] z_page;

  // Pointer split into word and page fields
  assign z_word = link.zptr[fsps_pkg::PAGE_LSB-1:fsps_pkg::WORD_LSB];
  assign z_page = link.zptr[fsps_pkg::ZPTR_W-1:fsps_pkg::PAGE_LSB];

  // No address check on the issuing code: any location may command
  assign spm_hit = link.spm_exec && (window_reg != 3'h0) && !eeprom_busy
                   && (state_reg == fsps_pkg::DS_IDLE);
  assign load_hit = spm_hit && (ctrl_reg == fsps_pkg::CMD_LOAD);
  assign write_done = (state_reg == fsps_pkg::DS_STREAM)
                      && (idx_reg == 5'(fsps_pkg::WORDS - 1));
  // EEPROM activity mid-load loses the partial page
  assign buf_clr = write_done
                   || (link.ctrl_wr && !eeprom_busy
                       && link.ctrl_wdata[fsps_pkg::CLR_BIT])
                   || (eeprom_busy && (mask_reg != '0));

  // Control register and its four-cycle arming window
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_reg <= fsps_pkg::CTRL_RESET;
      window_reg <= 3'h0;
    end
    else if (ce)
    begin
      if (link.ctrl_wr && !eeprom_busy)
      begin
        ctrl_reg <= link.ctrl_wdata;
        window_reg <= link.ctrl_wdata[fsps_pkg::CLR_BIT] ? 3'h0
                      : fsps_pkg::SPM_WINDOW;
      end
      else if (spm_hit || window_reg == 3'h1)
      begin
        // Unused or consumed command is dropped
        ctrl_reg <= fsps_pkg::CTRL_RESET;
        window_reg <= 3'h0;
      end
      else if (window_reg != 3'h0)
      begin
        window_reg <= window_reg - 3'h1;
      end
    end
  end

  // One buffer entry per word; loads land in any order
  genvar gi;
  generate
    for (gi = 0; gi < fsps_pkg::WORDS; gi++)
    begin : g_entry
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          buf_reg[gi] <= 16'h0000;
          mask_reg[gi] <= 1'b0;
        end
        else if (ce)
        begin
          if (buf_clr)
          begin
            buf_reg[gi] <= 16'h0000;
            mask_reg[gi] <= 1'b0;
          end
          else if (load_hit && z_word == 5'(gi))
          begin
            buf_reg[gi] <= link.data_word;
            mask_reg[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Operation sequencer: timed erase or write, then page stream
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= fsps_pkg::DS_IDLE;
      timer_reg <= 16'h0000;
      halt_reg <= 1'b0;
      page_reg <= 10'h000;
      idx_reg <= 5'h00;
    end
    else if (ce)
    begin
      case (state_reg)
        fsps_pkg::DS_IDLE:
        begin
          timer_reg <= 16'h0000;
          idx_reg <= 5'h00;
          if (spm_hit && ctrl_reg == fsps_pkg::CMD_ERASE)
          begin
            page_reg <= z_page;
            halt_reg <= 1'b1;
            state_reg <= fsps_pkg::DS_ERASE;
          end
          else if (spm_hit && ctrl_reg == fsps_pkg::CMD_WRITE)
          begin
            page_reg <= z_page;
            halt_reg <= 1'b1;
            state_reg <= fsps_pkg::DS_WRITE;
          end
        end
        fsps_pkg::DS_ERASE:
        begin
          timer_reg <= timer_reg + 16'h0001;
          if (timer_reg == PROG_CYCLES - 16'h0001)
          begin
            halt_reg <= 1'b0;
            state_reg <= fsps_pkg::DS_IDLE;
          end
        end
        fsps_pkg::DS_WRITE:
        begin
          // Stream adds WORDS cycles; default still ends below 3.4 ms
          timer_reg <= timer_reg + 16'h0001;
          if (timer_reg == PROG_CYCLES - 16'h0001)
          begin
            state_reg <= fsps_pkg::DS_STREAM;
          end
        end
        fsps_pkg::DS_STREAM:
        begin
          idx_reg <= idx_reg + 5'h01;
          if (write_done)
          begin
            halt_reg <= 1'b0;
            state_reg <= fsps_pkg::DS_IDLE;
          end
        end
        default:
        begin
          halt_reg <= 1'b0;
          state_reg <= fsps_pkg::DS_IDLE;
        end
      endcase
    end
  end

  // Flash array strobes, registered so the array sees clean levels
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      erase_reg <= 1'b0;
      prog_valid_reg <= 1'b0;
      prog_word_reg <= 5'h00;
      prog_data_reg <= 16'h0000;
      prog_loaded_reg <= 1'b0;
    end
    else if (ce)
    begin
      erase_reg <= (state_reg == fsps_pkg::DS_ERASE)
                   && (timer_reg == PROG_CYCLES - 16'h0001);
      prog_valid_reg <= (state_reg == fsps_pkg::DS_STREAM);
      prog_word_reg <= idx_reg;
      prog_data_reg <= buf_reg[idx_reg];
      // Unloaded words are flagged so the array leaves them erased
      prog_loaded_reg <= mask_reg[idx_reg];
    end
  end

  assign link.ctrl_rdata = ctrl_reg;
  assign link.cpu_halt = halt_reg;
  assign flash_busy = halt_reg;
  assign flash_erase = erase_reg;
  assign flash_erase_page = page_reg;
  assign flash_prog_valid = prog_valid_reg;
  assign flash_prog_page = page_reg;
  assign flash_prog_word = prog_word_reg;
  assign flash_prog_data = prog_data_reg;
  assign flash_prog_loaded = prog_loaded_reg;
endmodule // fsps_device

/* File: rtl/fsps_host.sv */
// CPU end: turns one user command into control write plus store strobe (clear: control write only).
// Assumes the user side holds cmd fields stable while cmd_valid is high.
module fsps_host (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  fsps_if.host link,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [15:0] cmd_zptr,
  input wire logic [15:0] cmd_data,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_error
);
  fsps_pkg::fsps_host_state_type state_reg;
  logic [1:0] gap_reg;
  logic ctrl_wr_reg;
  logic [7:0] ctrl_wdata_reg;
  logic spm_reg;
  logic [15:0] zptr_reg;
  logic [15:0] data_reg;
  logic ready_reg;
  logic done_reg;
  logic error_reg;
  logic [9:0] erased_page_reg;
  logic erased_valid_reg;
  logic [fsps_pkg::WORDS-1:0] loaded_reg;
  logic [4:0] c_word;
  logic [9:0] c_page;
  logic refuse;
  logic [7:0] pattern;

  assign c_word = cmd_zptr[fsps_pkg::PAGE_LSB-1:fsps_pkg::WORD_LSB];
  assign c_page = cmd_zptr[fsps_pkg::ZPTR_W-1:fsps_pkg::PAGE_LSB];

  always_comb
  begin
    pattern = 8'h00;
    refuse = 1'b0;
    case (fsps_pkg::fsps_op_type'(cmd_op))
      fsps_pkg::OP_LOAD:
      begin
        pattern = fsps_pkg::CMD_LOAD;
        refuse = loaded_reg[c_word];
      end
      fsps_pkg::OP_ERASE:
      begin
        pattern = fsps_pkg::CMD_ERASE;
      end
      fsps_pkg::OP_WRITE:
      begin
        pattern = fsps_pkg::CMD_WRITE;
        // Unerased or mismatched page would corrupt the array
        refuse = !erased_valid_reg || (erased_page_reg != c_page);
      end
      default:
      begin
        pattern = 8'(1 << fsps_pkg::CLR_BIT);
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= fsps_pkg::HS_IDLE;
      gap_reg <= 2'h0;
      ctrl_wr_reg <= 1'b0;
      ctrl_wdata_reg <= 8'h00;
      spm_reg <= 1'b0;
      zptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      error_reg <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_wr_reg <= 1'b0;
      spm_reg <= 1'b0;
      done_reg <= 1'b0;
      error_reg <= 1'b0;
      case (state_reg)
        fsps_pkg::HS_IDLE:
        begin
          ready_reg <= 1'b1;
          if (cmd_valid && ready_reg)
          begin
            ready_reg <= 1'b0;
            if (refuse)
            begin
              error_reg <= 1'b1;
            end
            else
            begin
              ctrl_wr_reg <= 1'b1;
              ctrl_wdata_reg <= pattern;
              // Write keeps only the page field, rest zero
              zptr_reg <=
                (fsps_pkg::fsps_op_type'(cmd_op) == fsps_pkg::OP_WRITE)
                ? {c_page, 6'h00} : cmd_zptr;
              data_reg <= cmd_data;
              state_reg <= fsps_pkg::HS_CTRL;
            end
          end
        end
        fsps_pkg::HS_CTRL:
        begin
          gap_reg <= 2'h0;
          if (ctrl_wdata_reg[fsps_pkg::CLR_BIT])
          begin
            done_reg <= 1'b1;
            state_reg <= fsps_pkg::HS_IDLE;
          end
          else if (fsps_pkg::HOST_GAP == 2'h0)
          begin
            spm_reg <= 1'b1;
            state_reg <= fsps_pkg::HS_EXEC;
          end
          else
          begin
            state_reg <= fsps_pkg::HS_GAP;
          end
        end
        fsps_pkg::HS_GAP:
        begin
          // Fixed gap, no interruption possible in between
          gap_reg <= gap_reg + 2'h1;
          if (gap_reg == fsps_pkg::HOST_GAP - 2'h1)
          begin
            spm_reg <= 1'b1;
            state_reg <= fsps_pkg::HS_EXEC;
          end
        end
        fsps_pkg::HS_EXEC:
        begin
          state_reg <= fsps_pkg::HS_WAIT;
        end
        fsps_pkg::HS_WAIT:
        begin
          if (!link.cpu_halt)
          begin
            done_reg <= 1'b1;
            state_reg <= fsps_pkg::HS_IDLE;
          end
        end
        default:
        begin
          state_reg <= fsps_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // Shadow of which words and page software has prepared
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      loaded_reg <= '0;
      erased_page_reg <= 10'h000;
      erased_valid_reg <= 1'b0;
    end
    else if (ce && state_reg == fsps_pkg::HS_IDLE && cmd_valid
             && ready_reg && !refuse)
    begin
      case (fsps_pkg::fsps_op_type'(cmd_op))
        fsps_pkg::OP_LOAD: loaded_reg[c_word] <= 1'b1;
        fsps_pkg::OP_ERASE:
        begin
          erased_page_reg <= c_page;
          erased_valid_reg <= 1'b1;
        end
        fsps_pkg::OP_WRITE:
        begin
          loaded_reg <= '0;
          erased_valid_reg <= 1'b0;
        end
        default: loaded_reg <= '0;
      endcase
    end
  end

  assign link.ctrl_wr = ctrl_wr_reg;
  assign link.ctrl_wdata = ctrl_wdata_reg;
  assign link.spm_exec = spm_reg;
  assign link.zptr = zptr_reg;
  assign link.data_word = data_reg;
  assign cmd_ready = ready_reg;
  assign cmd_done = done_reg;
  assign cmd_error = error_reg;
endmodule // fsps_host

/* File: rtl/fsps_if.sv */
// Link between the CPU end and the flash sequencer.
// Both ends run on the same clock; no crossing is needed.
interface fsps_if;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic [7:0] ctrl_rdata;
  logic spm_exec;
  logic [15:0] zptr;
  logic [15:0] data_word;
  logic cpu_halt;

  modport device
  (
    input ctrl_wr,
    input ctrl_wdata,
    output ctrl_rdata,
    input spm_exec,
    input zptr,
    input data_word,
    output cpu_halt
  );

  modport host
  (
    output ctrl_wr,
    output ctrl_wdata,
    input ctrl_rdata,
    output spm_exec,
    output zptr,
    output data_word,
    input cpu_halt
  );
endinterface

/* File: rtl/fsps_pkg.sv */
// Constants, encodings and timing shared by both ends of the sequencer link.
// Assumes a single 10 MHz clock shared by the CPU end and the sequencer.
// Notes on behaviour
// - Load one word per command, program whole pages.
// - Software erases page before writing it.
// - Buffer words may load in any order.
// - Erase and write must name same page.
// - Pattern 03 then store within four cycles erases.
// - Erase uses only the page field.
// - CPU stalls for the whole erase.
// - Command pair must not be interrupted.
// - Pattern 01 then store loads data word.
// - Load places word by word-in-page field.
// - Buffer clears on write, clear bit, reset.
// - Never load one location twice uncleared.
// - EEPROM write during loading discards buffer.
// - Pattern 05 then store writes page.
// - Write pointer holds page, other bits zero.
// - CPU stalls for the whole page write.
// - Commands accepted from any code address.
// - Erase or write lasts 3.2 to 3.4 ms.
// - EEPROM write blocks all programming commands.
// - Pointer splits into word and page fields.
package fsps_pkg;
  localparam int ZPTR_W = 16;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 8;
  localparam int WORD_W = 5;
  localparam int WORDS = 32;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = WORD_LSB + WORD_W;
  localparam int PAGE_W = ZPTR_W - PAGE_LSB;

  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CLR_BIT = 4;

  localparam logic [2:0] SPM_WINDOW = 3'h4;
  localparam logic [1:0] HOST_GAP = 2'h1;

  localparam int CLK_MHZ = 10;
  localparam int PROG_MIN_NS = 3_200_000;
  localparam int PROG_MAX_NS = 3_400_000;
  localparam logic [15:0] PROG_MIN_CYC =
    16'((PROG_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] PROG_MAX_CYC =
    16'((PROG_MAX_NS * CLK_MHZ) / 1000);

  typedef enum logic [1:0]
  {
    OP_LOAD = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2,
    OP_CLEAR = 2'h3
  } fsps_op_type;

  typedef enum logic [3:0]
  {
    DS_IDLE = 4'b0001,
    DS_ERASE = 4'b0010,
    DS_WRITE = 4'b0100,
    DS_STREAM = 4'b1000
  } fsps_dev_state_type;

  typedef enum logic [4:0]
  {
    HS_IDLE = 5'b00001,
    HS_CTRL = 5'b00010,
    HS_GAP = 5'b00100,
    HS_EXEC = 5'b01000,
    HS_WAIT = 5'b10000
  } fsps_host_state_type;
endpackage

/* File: verification/fsps_properties.sv */
// Concurrent checks on the CPU-to-sequencer link.
// Assumes ce held high and no EEPROM write around a command.
module fsps_properties #(
  parameter logic [15:0] PROG_CYCLES = fsps_pkg::PROG_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] ctrl_rdata,
  input wire logic spm_exec,
  input wire logic [15:0] zptr,
  input wire logic [15:0] data_word,
  input wire logic cpu_halt
);
  logic [15:0] halt_cnt_reg;
  logic write_op_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  always_ff @(posedge ref_clk)
    if (rst || !cpu_halt)
      halt_cnt_reg <= 16'h0000;
    else
      halt_cnt_reg <= halt_cnt_reg + 16'h0001;

  // Kind of the running operation, for the length check
  always_ff @(posedge ref_clk)
    if (rst)
      write_op_reg <= 1'b0;
    else if (spm_exec && !cpu_halt)
      write_op_reg <= (ctrl_rdata == fsps_pkg::CMD_WRITE);

  AST_ERASE_HALT:
    assert property (spm_exec && !cpu_halt &&
      ctrl_rdata == fsps_pkg::CMD_ERASE |=> cpu_halt)
    else $error("erase store did not halt the cpu");
  AST_WRITE_HALT:
    assert property (spm_exec && !cpu_halt &&
      ctrl_rdata == fsps_pkg::CMD_WRITE |=> cpu_halt)
    else $error("write store did not halt the cpu");
  AST_LOAD_NO_HALT:
    assert property (spm_exec && ctrl_rdata == fsps_pkg::CMD_LOAD
      |=> !cpu_halt)
    else $error("page load halted the cpu");
  AST_HALT_CAUSE:
    assert property ($rose(cpu_halt) |-> $past(spm_exec) &&
      ($past(ctrl_rdata) == fsps_pkg::CMD_ERASE ||
      $past(ctrl_rdata) == fsps_pkg::CMD_WRITE))
    else $error("cpu halted without a store");
  AST_HALT_LEN:
    assert property ($fell(cpu_halt) |-> halt_cnt_reg ==
      (write_op_reg ? PROG_CYCLES + 16'h0020 : PROG_CYCLES))
    else $error("halt length wrong");
  AST_STORE_CLEARS:
    assert property (spm_exec && !cpu_halt |=>
      ctrl_rdata == fsps_pkg::CTRL_RESET)
    else $error("control not cleared after store");
  AST_STORE_IN_WINDOW:
    assert property (ctrl_wr && !ctrl_wdata[fsps_pkg::CLR_BIT]
      |-> ##[1:4] spm_exec)
    else $error("store missed the window");
  AST_NO_CMD_HALTED:
    assert property (cpu_halt |-> !ctrl_wr && !spm_exec)
    else $error("command issued while halted");
  AST_WRITE_PAGE_ONLY:
    assert property (spm_exec && ctrl_rdata == fsps_pkg::CMD_WRITE
      |-> zptr[5:0] == 6'h00)
    else $error("write pointer low bits not zero");
endmodule // fsps_properties

/* File: verification/tb_flash_self_programming_sequencer.sv */
// Host drives the first sequencer; a second one is driven directly to
// miss the store window and hit the EEPROM lock.
// Assumes one 10 MHz clock and the package encodings.
module tb_flash_self_programming_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] PCYC = 16'h0014;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ee_busy = 1'b0;
  logic ee_busy2 = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [15:0] cmd_zptr = 16'h0000;
  logic [15:0] cmd_data = 16'h0000;
  logic cmd_ready, cmd_done, cmd_error;
  logic f_busy, f_erase, f_valid, f_loaded, s_bad;
  logic [9:0] f_erase_pg, f_pg, erased_pg;
  logic [4:0] f_word;
  logic [15:0] f_data;
  logic [15:0] s_data [32];
  logic [31:0] s_mask;
  int s_cnt;
  int busy_cnt = 0;
  int errors = 0;
  int n_checks = 0;
  fsps_if link();
  fsps_if link2();

  fsps_device #(.PROG_CYCLES(PCYC)) fsps_device_i (.ref_clk(ref_clk),
    .rst(rst), .ce(1'b1), .link(link.device), .eeprom_busy(ee_busy),
    .flash_busy(f_busy), .flash_erase(f_erase),
    .flash_erase_page(f_erase_pg), .flash_prog_valid(f_valid),
    .flash_prog_page(f_pg), .flash_prog_word(f_word),
    .flash_prog_data(f_data), .flash_prog_loaded(f_loaded));
  fsps_host fsps_host_i (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .link(link.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_zptr(cmd_zptr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_error(cmd_error));
  fsps_device #(.PROG_CYCLES(PCYC)) fsps_device_i2 (.ref_clk(ref_clk),
    .rst(rst), .ce(1'b1), .link(link2.device), .eeprom_busy(ee_busy2),
    .flash_busy(), .flash_erase(), .flash_erase_page(),
    .flash_prog_valid(), .flash_prog_page(), .flash_prog_word(),
    .flash_prog_data(), .flash_prog_loaded());
  fsps_properties #(.PROG_CYCLES(PCYC)) fsps_properties_i (
    .ref_clk(ref_clk), .rst(rst), .ctrl_wr(link.ctrl_wr),
    .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata),
    .spm_exec(link.spm_exec), .zptr(link.zptr),
    .data_word(link.data_word), .cpu_halt(link.cpu_halt));

  initial
    forever #50 ref_clk = ~ref_clk;

  // Capture of the page stream, stored by word index
  always @(posedge ref_clk)
  begin
    if (f_erase)
      erased_pg <= f_erase_pg;
    if (f_busy)
      busy_cnt <= busy_cnt + 1;
    if (f_valid)
    begin
      if (f_word !== s_cnt[4:0] || f_pg !== erased_pg)
        s_bad <= 1'b1;
      s_data[f_word] <= f_data;
      s_mask[f_word] <= f_loaded;
      s_cnt <= s_cnt + 1;
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic limit(input int n);
    if (n >= 200)
    begin
      errors++;
      $display("mismatch wait expected end seen none");
      stop_test();
    end
  endtask

  task automatic cmd(input logic [1:0] op, input logic [15:0] z,
      input logic [15:0] d, output logic err);
    int n;
    for (n = 0; n < 200 && cmd_ready !== 1'b1; n++)
      @(negedge ref_clk);
    limit(n);
    cmd_op = op;
    cmd_zptr = z;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 200 && cmd_done !== 1'b1 && cmd_error !== 1'b1; n++)
      @(negedge ref_clk);
    limit(n);
    err = cmd_error;
  endtask

  task automatic load(input logic [4:0] w, input logic exp_err);
    logic e;
    cmd(fsps_pkg::OP_LOAD, {10'h155, w, 1'b0}, {11'h600, w}, e);
    chk("load refused", e, exp_err);
  endtask

  // Erase with junk word bits, refused write to another page, real write
  task automatic prog(input logic [9:0] pg, input logic [31:0] mask);
    logic e;
    s_cnt = 0;
    s_bad = 1'b0;
    busy_cnt = 0;
    cmd(fsps_pkg::OP_ERASE, {pg, 6'h2b}, 16'hffff, e);
    chk("erase page", erased_pg, pg);
    chk("erase time", busy_cnt, 32'(PCYC));
    cmd(fsps_pkg::OP_WRITE, {pg + 10'h001, 6'h00}, 16'h0000, e);
    chk("other page write", e, 1'b1);
    busy_cnt = 0;
    cmd(fsps_pkg::OP_WRITE, {pg, 6'h00}, 16'hffff, e);
    chk("write refused", e, 1'b0);
    chk("write time", busy_cnt, 32'(PCYC) + 32'(fsps_pkg::WORDS));
    chk("stream words", s_cnt, 32);
    chk("stream order", s_bad, 1'b0);
    chk("loaded mask", s_mask, mask);
    for (int i = 0; i < 32; i++)
      if (mask[i])
        chk("word data", s_data[i], {11'h600, 5'(i)});
  endtask

  task automatic t_page();
    logic e;
    load(5'd7, 1'b0);
    load(5'd0, 1'b0);
    load(5'd31, 1'b0);
    load(5'd12, 1'b0);
    load(5'd7, 1'b1);
    cmd(fsps_pkg::OP_WRITE, 16'h0140, 16'h0000, e);
    chk("unerased write", e, 1'b1);
    prog(10'h005, 32'h8000_1081);
  endtask

  task automatic t_clear();
    logic e;
    load(5'd3, 1'b0);
    cmd(fsps_pkg::OP_CLEAR, 16'h0000, 16'h0000, e);
    chk("clear refused", e, 1'b0);
    prog(10'h009, 32'h0000_0000);
    load(5'd3, 1'b0);
    ee_busy = 1'b1;
    repeat (2) @(negedge ref_clk);
    ee_busy = 1'b0;
    prog(10'h00a, 32'h0000_0000);
  endtask

  // Store gap counted in cycles after the control write
  task automatic raw(input logic [7:0] wd, input int gap,
      input logic busy, input logic exp);
    int n;
    ee_busy2 = busy;
    link2.ctrl_wdata = wd;
    link2.ctrl_wr = 1'b1;
    @(negedge ref_clk);
    link2.ctrl_wr = 1'b0;
    repeat (gap - 1) @(negedge ref_clk);
    link2.spm_exec = 1'b1;
    @(negedge ref_clk);
    link2.spm_exec = 1'b0;
    ee_busy2 = 1'b0;
    @(negedge ref_clk);
    chk("halt started", link2.cpu_halt, exp);
    chk("command dropped", link2.ctrl_rdata, 8'h00);
    for (n = 0; n < 200 && link2.cpu_halt !== 1'b0; n++)
      @(negedge ref_clk);
    limit(n);
  endtask

  initial
  begin
    link2.ctrl_wr = 1'b0;
    link2.ctrl_wdata = 8'h00;
    link2.spm_exec = 1'b0;
    link2.zptr = 16'h0140;
    link2.data_word = 16'h0000;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("reset halt", link.cpu_halt, 1'b0);
    chk("reset control", link.ctrl_rdata, 8'h00);
    t_page();
    t_clear();
    raw(fsps_pkg::CMD_ERASE, 4, 1'b0, 1'b1);
    raw(fsps_pkg::CMD_WRITE, 1, 1'b0, 1'b1);
    raw(fsps_pkg::CMD_ERASE, 5, 1'b0, 1'b0);
    raw(fsps_pkg::CMD_WRITE, 2, 1'b1, 1'b0);
    raw(fsps_pkg::CMD_LOAD, 3, 1'b0, 1'b0);
    raw(8'h07, 2, 1'b0, 1'b0);
    stop_test();
  end
endmodule // tb_flash_self_programming_sequencer
